// [design/sos_pkg.sv]
// package: codes, register map and constants of the status selector
package sos_pkg;
  localparam int NTERM = 3;
  localparam int CODE_W = 9;
  localparam int FN_W = 8;
  localparam int INV_BIT = 8;
  // function codes, low two digits of the selection
  localparam logic [FN_W-1:0] FN_BB_NO = 8'h08;
  localparam logic [FN_W-1:0] FN_THRU = 8'h0f;
  localparam logic [FN_W-1:0] FN_DOWN = 8'h1a;
  localparam logic [FN_W-1:0] FN_BB_NC = 8'h1b;
  localparam logic [FN_W-1:0] FN_RST_OK = 8'h1e;
  localparam logic [FN_W-1:0] FN_OVL = 8'h1f;
  localparam logic [FN_W-1:0] FN_HOT = 8'h20;
  localparam logic [FN_W-1:0] FN_MAINT = 8'h2f;
  localparam logic [FN_W-1:0] FN_TRQ = 8'h30;
  localparam logic [FN_W-1:0] FN_FOUT = 8'h37;
  localparam logic [FN_W-1:0] FN_BRAKE = 8'h50;
  localparam logic [FN_W-1:0] FN_CONT = 8'h51;
  localparam logic [FN_W-1:0] FN_LL_DIR = 8'h54;
  localparam logic [FN_W-1:0] FN_LL_DONE = 8'h55;
  localparam logic [FN_W-1:0] FN_SAFE = 8'h58;
  localparam logic [CODE_W-1:0] SEL_RST = 9'h00f;
  // condition vector indices
  localparam int C_DOWN = 0;
  localparam int C_BB = 1;
  localparam int C_RST_OK = 2;
  localparam int C_OVL = 3;
  localparam int C_HOT = 4;
  localparam int C_MAINT = 5;
  localparam int C_TRQ = 6;
  localparam int C_FOUT = 7;
  localparam int C_BRAKE = 8;
  localparam int C_CONT = 9;
  localparam int C_LL_UP = 10;
  localparam int C_LL_DONE = 11;
  localparam int C_SAFE = 12;
  localparam int NCOND = 13;
  // register byte offsets; selection n sits at A_SEL0 + 4*n
  localparam logic [7:0] A_SEL0 = 8'h00;
  localparam logic [7:0] A_THRU = 8'h0c;
  localparam logic [7:0] A_TERM = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_IRQ_STAT = 8'h18;
  localparam logic [7:0] A_IRQ_MASK = 8'h1c;
  localparam logic [7:0] A_CTRL = 8'h20;
  localparam logic [7:0] A_OVL_TRIP = 8'h24;
  localparam logic [7:0] A_HOT_LEVEL = 8'h28;
  localparam logic [7:0] A_RETRY = 8'h2c;
  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LIMIT_LSB = 4;
  localparam int CTRL_CLR_BIT = 8;
  localparam logic [3:0] LIMIT_RST = 4'h3;
  localparam logic [15:0] OVL_TRIP_RST = 16'h1000;
  localparam logic [7:0] HOT_LEVEL_RST = 8'h5a;
  // overload alarm at nine tenths of the trip level
  localparam logic [3:0] OVL_NUM = 4'h9;
  localparam logic [3:0] OVL_DEN = 4'ha;
  // interrupt status bits
  localparam int I_EXH = 0;
  localparam int I_OVL = 1;
  localparam int I_HOT = 2;
  localparam int I_MAINT = 3;
  localparam int I_SAFE_OPEN = 4;
  localparam int I_TERM_CHG = 5;
  localparam int NIRQ = 6;
  typedef enum logic [1:0] {
    MODE_VF,
    MODE_OL_VECTOR,
    MODE_CL_VECTOR,
    MODE_CL_VECTOR_PM
  } sos_mode_type;
  typedef enum logic [1:0] {
    ARS_IDLE,
    ARS_FAULT,
    ARS_TRIED,
    ARS_EXHAUSTED
  } sos_ars_type;
endpackage : sos_pkg

// [design/sos_term_mux.sv]
// module: contact selection for one output terminal
`timescale 1ns/100ps
`default_nettype none
module sos_term_mux
  import sos_pkg::*;
(
  input wire logic [CODE_W-1:0] sel_i,
  input wire logic [NCOND-1:0] cond_i,
  input wire logic thru_i,
  output logic contact_o
);
  logic [FN_W-1:0] fn;
  logic inv;
  logic raw;
  logic valid;

  assign fn = sel_i[FN_W-1:0];
  assign inv = sel_i[INV_BIT];

  always_comb
  begin
    raw = 1'b0;
    valid = 1'b1;
    unique case (fn)
      FN_BB_NO: raw = cond_i[C_BB]; // R17
      FN_DOWN: raw = cond_i[C_DOWN]; // R1
      FN_BB_NC: raw = !cond_i[C_BB]; // R2
      FN_RST_OK: raw = cond_i[C_RST_OK]; // R3
      FN_OVL: raw = cond_i[C_OVL]; // R5
      FN_HOT: raw = cond_i[C_HOT]; // R6
      FN_MAINT: raw = cond_i[C_MAINT]; // R7
      FN_TRQ: raw = cond_i[C_TRQ]; // R8
      FN_FOUT: raw = cond_i[C_FOUT]; // R9
      FN_BRAKE: raw = cond_i[C_BRAKE]; // R10
      FN_CONT: raw = cond_i[C_CONT]; // R11
      FN_LL_DIR: raw = cond_i[C_LL_UP]; // R12
      FN_LL_DONE: raw = cond_i[C_LL_DONE]; // R13
      FN_SAFE: raw = cond_i[C_SAFE]; // R14
      FN_THRU: raw = thru_i; // R16
      default: valid = 1'b0; // R19
    endcase
  end

  always_comb
  begin
    if (!valid)
      contact_o = 1'b0; // R19
    else if (fn == FN_THRU)
      contact_o = inv ? 1'b0 : raw; // R16
    else
      contact_o = raw ^ inv; // R15
  end
endmodule : sos_term_mux
`default_nettype wire

// [design/sos_status_selector.sv]
// module: multi-function status output selector with wishbone registers
//
// Behaviour
// (R1) code 1A: contact closed while driving down, else open
// (R2) code 1B: contact open during baseblock, closed otherwise
// (R3) code 1E: contact closed after fault cleared by an automatic reset
// (R4) attempts exhausted: raise a fault and open the 1E contact
// (R5) code 1F: closed when overload estimate exceeds 90% of trip level
// (R6) code 20: closed when heatsink reaches the overheat alarm level
// (R7) code 2F: closed when fan, capacitors or precharge relay need service
// (R8) code 30: closed at torque limit, only in the vector modes
// (R9) code 37: closed while outputting frequency; open stopped or braking
// (R10) code 50: closed requests brake release, open requests brake apply
// (R11) code 51: closed requests output contactor closure
// (R12) code 54: light-load direction, closed up, open down
// (R13) code 55: open during light-load search, closed when complete
// (R14) code 58: closed when both safe-disable inputs are closed
// (R15) codes 100 to 158: same functions with the contact inverted, except 10F, which holds the contact open
// (R16) through code: no internal drive, contact set over the bus
// (R17) code 8: closed during baseblock, open otherwise
// (R18) contacts are registered and follow selections next cycle
// (R19) undefined codes hold the contact open
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module sos_status_selector
  import sos_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic run_down_i,
  input wire logic running_i,
  input wire logic baseblock_i,
  input wire logic dc_inject_i,
  input wire logic short_brake_i,
  input wire logic fault_i,
  input wire logic reset_attempt_i,
  input wire logic [15:0] motor_overload_estimate_i,
  input wire logic [7:0] heatsink_temp_i,
  input wire logic maint_fan_i,
  input wire logic maint_cap_i,
  input wire logic maint_relay_i,
  input wire logic torque_limit_i,
  input wire logic brake_release_i,
  input wire logic contactor_close_i,
  input wire logic light_load_up_i,
  input wire logic light_load_busy_i,
  input wire logic [1:0] safe_disable_inputs_i,
  output logic [NTERM-1:0] term_o,
  output logic retry_fault_o,
  output logic irq_o
);
  logic [CODE_W-1:0] sel_q [NTERM];
  logic [NTERM-1:0] thru_q, term_q, term_d;
  logic [NIRQ-1:0] irq_stat_q, irq_mask_q, irq_evt;
  logic irq_q, clr_q, exh_q, fault_prev_q, fault_rise;
  logic ack_q, req, wr, vector_mode;
  sos_mode_type mode_q;
  sos_ars_type ars_q;
  logic [3:0] limit_q, cnt_q;
  logic [15:0] ovl_trip_q;
  logic [7:0] hot_level_q;
  logic [1:0] safe_m_q, safe_q;
  logic [NCOND-1:0] cond, cond_prev_q;
  logic [31:0] dat_q;
  logic [19:0] ovl_lhs, ovl_rhs;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic is_sel(input logic [7:0] adr, input int n);
    return adr == A_SEL0 + 8'(4 * n);
  endfunction : is_sel

  // bus: single-cycle ack one edge after the request is taken
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;

  // safe-disable pins are asynchronous
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      {safe_q, safe_m_q} <= '0;
    else
      {safe_q, safe_m_q} <= {safe_m_q, safe_disable_inputs_i};
  end

  assign ovl_lhs = 20'(motor_overload_estimate_i) * 20'(OVL_DEN);
  assign ovl_rhs = 20'(ovl_trip_q) * 20'(OVL_NUM);
  assign vector_mode = mode_q != MODE_VF;
  assign fault_rise = fault_i && !fault_prev_q;

  always_comb
  begin
    cond = '0;
    cond[C_DOWN] = running_i && run_down_i; // R1
    cond[C_BB] = baseblock_i; // R2
    cond[C_RST_OK] = ars_q == ARS_TRIED && !fault_i; // R3
    cond[C_OVL] = ovl_lhs > ovl_rhs; // R5
    cond[C_HOT] = heatsink_temp_i >= hot_level_q; // R6
    cond[C_MAINT] = maint_fan_i || maint_cap_i || maint_relay_i; // R7
    cond[C_TRQ] = torque_limit_i && vector_mode; // R8
    cond[C_FOUT] = running_i && !baseblock_i && !dc_inject_i
                   && !short_brake_i; // R9
    cond[C_BRAKE] = brake_release_i; // R10
    cond[C_CONT] = contactor_close_i; // R11
    cond[C_LL_UP] = light_load_up_i; // R12
    cond[C_LL_DONE] = !light_load_busy_i; // R13
    cond[C_SAFE] = safe_q == 2'h3; // R14
  end

  for (genvar t = 0; t < NTERM; t++)
  begin : g_term
    sos_term_mux u_mux (
      .sel_i(sel_q[t]),
      .cond_i(cond),
      .thru_i(thru_q[t]),
      .contact_o(term_d[t])
    );
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      term_q <= '0;
    else
      term_q <= term_d; // R18
  end

  // automatic fault reset tracking
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ars_q <= ARS_IDLE;
      cnt_q <= 4'h0;
      exh_q <= 1'b0;
      fault_prev_q <= 1'b0;
    end
    else
    begin
      fault_prev_q <= fault_i;
      if (clr_q)
      begin
        ars_q <= ARS_IDLE;
        cnt_q <= 4'h0;
        exh_q <= 1'b0;
      end
      else if (irq_evt[I_EXH])
      begin
        ars_q <= ARS_EXHAUSTED; // R4
        exh_q <= 1'b1; // R4
      end
      else
      begin
        unique case (ars_q)
          ARS_IDLE:
            if (fault_rise)
              ars_q <= ARS_FAULT;
          ARS_FAULT:
            if (reset_attempt_i)
            begin
              ars_q <= ARS_TRIED; // R3
              cnt_q <= cnt_q + 4'h1;
            end
          ARS_TRIED:
            if (fault_rise)
              ars_q <= ARS_FAULT;
          ARS_EXHAUSTED:
            ars_q <= ARS_EXHAUSTED;
        endcase
      end
    end
  end

  // interrupt events: edges of selected conditions, any contact change, and retry exhaustion
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cond_prev_q <= '0;
    else
      cond_prev_q <= cond;
  end

  always_comb
  begin
    irq_evt = '0;
    irq_evt[I_EXH] = (ars_q != ARS_EXHAUSTED) && (ars_q != ARS_IDLE)
                     && cnt_q >= limit_q && !clr_q
                     && (ars_q == ARS_FAULT || fault_rise);
    irq_evt[I_OVL] = cond[C_OVL] && !cond_prev_q[C_OVL];
    irq_evt[I_HOT] = cond[C_HOT] && !cond_prev_q[C_HOT];
    irq_evt[I_MAINT] = cond[C_MAINT] && !cond_prev_q[C_MAINT];
    irq_evt[I_SAFE_OPEN] = !cond[C_SAFE] && cond_prev_q[C_SAFE];
    irq_evt[I_TERM_CHG] = term_d != term_q;
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_q <= '0;
    else if (wr && wb_adr_i == A_IRQ_STAT && wb_sel_i[0])
      irq_stat_q <= (irq_stat_q & ~wb_dat_i[NIRQ-1:0]) | irq_evt;
    else
      irq_stat_q <= irq_stat_q | irq_evt;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_stat_q & irq_mask_q);
  end

  // register writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int t = 0; t < NTERM; t++)
        sel_q[t] <= SEL_RST;
      thru_q <= '0;
      irq_mask_q <= '0;
      mode_q <= MODE_VF;
      limit_q <= LIMIT_RST;
      ovl_trip_q <= OVL_TRIP_RST;
      hot_level_q <= HOT_LEVEL_RST;
      clr_q <= 1'b0;
    end
    else
    begin
      clr_q <= 1'b0;
      if (wr)
      begin
        for (int t = 0; t < NTERM; t++)
          if (is_sel(wb_adr_i, t))
            sel_q[t] <= CODE_W'(merge(32'(sel_q[t]), wb_dat_i, wb_sel_i));
        if (wb_adr_i == A_THRU)
          thru_q <= NTERM'(merge(32'(thru_q), wb_dat_i, wb_sel_i)); // R16
        if (wb_adr_i == A_IRQ_MASK)
          irq_mask_q <= NIRQ'(merge(32'(irq_mask_q), wb_dat_i, wb_sel_i));
        if (wb_adr_i == A_CTRL && wb_sel_i[0])
        begin
          mode_q <= sos_mode_type'(wb_dat_i[CTRL_MODE_LSB +: 2]);
          limit_q <= wb_dat_i[CTRL_LIMIT_LSB +: 4];
        end
        if (wb_adr_i == A_CTRL && wb_sel_i[1])
          clr_q <= wb_dat_i[CTRL_CLR_BIT];
        if (wb_adr_i == A_OVL_TRIP)
          ovl_trip_q <= 16'(merge(32'(ovl_trip_q), wb_dat_i, wb_sel_i));
        if (wb_adr_i == A_HOT_LEVEL && wb_sel_i[0])
          hot_level_q <= wb_dat_i[7:0];
      end
    end
  end

  // register reads, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= req;
      dat_q <= '0;
      if (req && !wb_we_i)
      begin
        for (int t = 0; t < NTERM; t++)
          if (is_sel(wb_adr_i, t))
            dat_q <= 32'(sel_q[t]);
        unique case (wb_adr_i)
          A_THRU: dat_q <= 32'(thru_q);
          A_TERM: dat_q <= 32'(term_q); // R16
          A_STATUS: dat_q <= 32'(cond);
          A_IRQ_STAT: dat_q <= 32'(irq_stat_q);
          A_IRQ_MASK: dat_q <= 32'(irq_mask_q);
          A_CTRL: dat_q <= {24'h0, limit_q, 2'h0, mode_q};
          A_OVL_TRIP: dat_q <= 32'(ovl_trip_q);
          A_HOT_LEVEL: dat_q <= 32'(hot_level_q);
          A_RETRY: dat_q <= {25'h0, exh_q, ars_q, cnt_q};
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      retry_fault_o <= 1'b0;
    else
      retry_fault_o <= exh_q; // R4
  end

  assign term_o = term_q;
  assign irq_o = irq_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_tried;
    (ars_q == ARS_FAULT && cnt_q < limit_q && reset_attempt_i && !clr_q)
    ##1 (!fault_i && !clr_q);
  endsequence

  a_down_close: assert property ( // R1
    sel_q[0] == 9'(FN_DOWN) && running_i && run_down_i |=> term_q[0])
    else $error("down contact not closed");
  a_bb_nc_open: assert property ( // R2
    sel_q[0] == 9'(FN_BB_NC) && baseblock_i |=> !term_q[0])
    else $error("n.c. baseblock contact not open");
  a_reset_ok_close: assert property ( // R3
    sel_q[0] == 9'(FN_RST_OK) ##0 s_tried |=> term_q[0])
    else $error("reset-enabled contact not closed");
  a_retry_exhaust: assert property ( // R4
    ars_q == ARS_TRIED && fault_rise && cnt_q >= limit_q && !clr_q
    |=> exh_q ##1 retry_fault_o && !cond[C_RST_OK])
    else $error("exhausted reset not flagged");
  a_ovl_close: assert property ( // R5
    sel_q[0] == 9'(FN_OVL) && cond[C_OVL] |=> term_q[0])
    else $error("overload contact not closed");
  a_trq_vf_open: assert property ( // R8
    sel_q[0] == 9'(FN_TRQ) && mode_q == MODE_VF |=> !term_q[0])
    else $error("torque contact closed outside vector mode");
  a_fout_brake: assert property ( // R9
    sel_q[0] == 9'(FN_FOUT) && dc_inject_i |=> !term_q[0])
    else $error("frequency contact closed while braking");
  a_safe_close: assert property ( // R14
    sel_q[0] == 9'(FN_SAFE) && safe_q == 2'h3 |=> term_q[0])
    else $error("safe contact not closed");
  a_inverse_bb: assert property ( // R15
    sel_q[0] == {1'b1, FN_BB_NO} |=> term_q[0] == !$past(baseblock_i))
    else $error("inverted baseblock contact wrong");
  a_thru_follow: assert property ( // R16
    sel_q[0] == 9'(FN_THRU) |=> term_q[0] == $past(thru_q[0]))
    else $error("through contact not from bus value");
  a_unknown_open: assert property ( // R19
    sel_q[2][FN_W-1:0] == 8'hc3 |=> !term_q[2])
    else $error("undefined code drives contact");
endmodule : sos_status_selector
`default_nettype wire

// [bench/sos_ctrl_model.sv]
// model: elevator controller acting on brake and contactor contacts
`timescale 1ns/100ps
`default_nettype none
module sos_ctrl_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic brake_term_i,
  input wire logic cont_term_i,
  output logic brake_applied_o,
  output logic contactor_closed_o
);
  // brake falls in whenever the contact is open, reset included
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      brake_applied_o <= 1'b1;
    end
    else
    begin
      brake_applied_o <= !brake_term_i;
    end
  end

  // contactor drops out on the clock edge after the contact is released
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      contactor_closed_o <= 1'b0;
    end
    else
    begin
      contactor_closed_o <= cont_term_i;
    end
  end
endmodule : sos_ctrl_model
`default_nettype wire

// [bench/sos_status_selector_test.sv]
// testbench: random and directed checks of the status output selector
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    n_compared++; \
    if ((gt) !== (ex)) \
    begin \
      error_cnt++; \
      $display("ERROR %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module sos_status_selector_test
  import sos_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd, seed = 32'h41c9b185;
  logic ack, retry, irq, brk_ap, con_cl;
  logic run_dn = 0, run = 0, bb = 0, dci = 0, sbr = 0, flt = 0, att = 0;
  logic mf = 0, mc = 0, mr = 0, trq = 0, brk = 0, con = 0, llu = 0, llb = 1;
  logic [15:0] ovl = 16'h0;
  logic [7:0] tmp = 8'h0;
  logic [1:0] sd = 2'b00, md = 2'b00;
  logic [2:0] thr = 3'b000;
  logic [NTERM-1:0] term;
  int error_cnt = 0, n_compared = 0;
  localparam logic [7:0] FNS [16] = '{FN_BB_NO, FN_THRU, FN_DOWN, FN_BB_NC,
    FN_OVL, FN_HOT, FN_MAINT, FN_TRQ, FN_FOUT, FN_BRAKE, FN_CONT, FN_LL_DIR,
    FN_LL_DONE, FN_SAFE, 8'h21, 8'h59};

  sos_status_selector i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .run_down_i(run_dn),
    .running_i(run), .baseblock_i(bb), .dc_inject_i(dci),
    .short_brake_i(sbr), .fault_i(flt), .reset_attempt_i(att),
    .motor_overload_estimate_i(ovl), .heatsink_temp_i(tmp),
    .maint_fan_i(mf), .maint_cap_i(mc), .maint_relay_i(mr),
    .torque_limit_i(trq), .brake_release_i(brk), .contactor_close_i(con),
    .light_load_up_i(llu), .light_load_busy_i(llb),
    .safe_disable_inputs_i(sd), .term_o(term), .retry_fault_o(retry),
    .irq_o(irq));
  sos_ctrl_model i_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .brake_term_i(term[0]), .cont_term_i(term[0]),
    .brake_applied_o(brk_ap), .contactor_closed_o(con_cl));

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic fexp(input logic [8:0] c, input int t);
    logic v;
    logic ok;
    ok = 1'b1;
    v = 1'b0;
    case (c[7:0])
      FN_BB_NO: v = bb;
      FN_THRU:
      begin
        v = thr[t];
        ok = !c[8];
      end
      FN_DOWN: v = run & run_dn;
      FN_BB_NC: v = !bb;
      FN_OVL: v = int'(ovl) * 10 > 32'h1000 * 9;
      FN_HOT: v = tmp >= HOT_LEVEL_RST;
      FN_MAINT: v = mf | mc | mr;
      FN_TRQ: v = trq & (md != 2'b00);
      FN_FOUT: v = run & !bb & !dci & !sbr;
      FN_BRAKE: v = brk;
      FN_CONT: v = con;
      FN_LL_DIR: v = llu;
      FN_LL_DONE: v = !llb;
      FN_SAFE: v = &sd;
      default: ok = 1'b0;
    endcase
    return ok & (v ^ c[8]);
  endfunction : fexp

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50)
    begin
      `CHK("ack", 1'b1, ack)
      summarize();
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic drive_rand();
    logic [31:0] r;
    r = xs();
    @(posedge clk_i);
    run_dn <= r[0];
    run <= r[1];
    bb <= r[2];
    dci <= r[3] & r[4];
    sbr <= r[5] & r[6];
    flt <= r[7];
    mf <= r[8] & r[9];
    mc <= r[10] & r[11];
    mr <= r[12] & r[13];
    trq <= r[14];
    brk <= r[15];
    con <= r[16];
    llu <= r[17];
    llb <= r[18];
    sd <= r[20:19];
    tmp <= r[28:21];
    ovl <= 16'h0e00 + {8'h00, seed[7:0] ^ r[31:24]};
  endtask : drive_rand

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    summarize();
  end

  initial
  begin
    logic [8:0] c2;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    `CHK("term reset", 3'b000, term)
    wb(1'b0, A_SEL0, 32'h0, rd);
    `CHK("sel0 reset", 32'h0000000f, rd)
    wb(1'b0, A_OVL_TRIP, 32'h0, rd);
    `CHK("trip reset", 32'h00001000, rd)
    wb(1'b0, A_HOT_LEVEL, 32'h0, rd);
    `CHK("level reset", 32'h0000005a, rd)
    wb(1'b0, 8'hfc, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
    bb <= 1'b0;
    wr(A_SEL0, 32'h108);
    settle(2);
    `CHK("inverted", 1'b1, term[0])
    bb <= 1'b1;
    wr(A_SEL0, 32'h008);
    #1;
    `CHK("latency", 1'b1, term[0])
    $display("test latency done");
    for (int i = 0; i < 192; i++)
    begin
      if (i % 16 == 0)
      begin
        rd = xs();
        md = rd[1:0];
        thr = rd[4:2];
        wr(A_CTRL, {24'h0, 4'h3, 2'b00, md});
        wr(A_THRU, {29'h0, thr});
      end
      c2 = {seed[5], 8'hc3};
      wr(A_SEL0, {24'h0, FNS[i % 16]});
      wr(A_SEL0 + 8'h04, {23'h0, 1'b1, FNS[i % 16]});
      wr(A_SEL0 + 8'h08, {23'h0, c2});
      drive_rand();
      settle(5);
      `CHK("term0", fexp({1'b0, FNS[i % 16]}, 0), term[0])
      `CHK("term1", fexp({1'b1, FNS[i % 16]}, 1), term[1])
      `CHK("term2", fexp(c2, 2), term[2])
      if (FNS[i % 16] == FN_BRAKE) `CHK("brake", !brk, brk_ap)
      if (FNS[i % 16] == FN_CONT) `CHK("contactor", con, con_cl)
    end
    $display("test table done");
    wr(A_SEL0, {24'h0, FN_OVL});
    for (int k = 0; k < 2; k++)
    begin
      ovl <= 16'h0e66 + 16'(k);
      settle(3);
      `CHK("overload edge", k[0], term[0])
    end
    $display("test overload done");
    flt <= 1'b0;
    att <= 1'b0;
    wr(A_CTRL, 32'h120);
    wr(A_SEL0, {24'h0, FN_RST_OK});
    wr(A_IRQ_MASK, 32'h0);
    wr(A_IRQ_STAT, 32'h3f);
    for (int k = 0; k < 2; k++)
    begin
      flt <= 1'b1;
      settle(2);
      flt <= 1'b0;
      @(posedge clk_i);
      att <= 1'b1;
      @(posedge clk_i);
      att <= 1'b0;
      settle(3);
      `CHK("reset ok", 1'b1, term[0])
    end
    flt <= 1'b1;
    settle(4);
    `CHK("exhausted", 1'b1, retry)
    `CHK("exhausted open", 1'b0, term[0])
    wb(1'b0, A_RETRY, 32'h0, rd);
    `CHK("retry reg", 32'h00000072, rd)
    `CHK("irq masked", 1'b0, irq)
    wr(A_IRQ_MASK, 32'h1);
    settle(2);
    `CHK("irq raised", 1'b1, irq)
    wr(A_IRQ_STAT, 32'h1);
    settle(2);
    `CHK("irq cleared", 1'b0, irq)
    flt <= 1'b0;
    wr(A_CTRL, 32'h130);
    settle(2);
    `CHK("retry clear", 1'b0, retry)
    $display("test auto reset done");
    summarize();
  end
endmodule : sos_status_selector_test
`default_nettype wire
